// ==== core/octr_pkg.sv ====
`default_nettype none
package octr_pkg;
    // register byte addresses
    localparam logic [7:0] TRIM_ADDR = 8'h00;
    localparam logic [7:0] REFCTL_ADDR = 8'h04;
    localparam logic [7:0] OSCSTAT_ADDR = 8'h08;
    localparam logic [7:0] OSCCFG_ADDR = 8'h0C;
    // trim register
    localparam int TRIM_LSB = 0;
    localparam int TRIM_W = 6;
    localparam logic [5:0] TRIM_RST = 6'h00;
    // reference control register
    localparam int REF_EN_BIT = 15;
    localparam int REF_SLP_BIT = 13;
    localparam int REF_SEL_BIT = 12;
    localparam int REF_DIV_LSB = 8;
    localparam int REF_DIV_W = 4;
    localparam logic [15:0] REF_RST = 16'h0000;
    // configuration and status register layout
    localparam int SUBMODE_LSB = 0;
    localparam int INITSRC_LSB = 8;
    localparam int CURSRC_LSB = 12;
    // submode codes
    localparam logic [1:0] SUB_EXT = 2'h0;
    localparam logic [1:0] SUB_MED = 2'h1;
    localparam logic [1:0] SUB_HIGH = 2'h2;
    localparam logic [1:0] SUB_OFF = 2'h3;
    // source selections and configuration reset values
    localparam logic [2:0] SRC_PRIMARY = 3'h2;
    localparam logic [2:0] SRC_PRIMARY_X4 = 3'h3;
    localparam logic [2:0] CFG_RST_SRC = 3'h0;
    localparam logic [1:0] CFG_RST_SUB = 2'h3;
    // start-up timer and pll multiplier
    localparam int STARTUP_W = 10;
    localparam int STARTUP_CYCLES = 1024;
    localparam int PLL_MULT = 4;
    typedef enum logic [5:0] {
        OCTR_EXT = 6'h01,
        OCTR_EXT_X4 = 6'h02,
        OCTR_HIGH = 6'h04,
        OCTR_HIGH_X4 = 6'h08,
        OCTR_MED = 6'h10,
        OCTR_MED_X4 = 6'h20
    } octr_mode_e;
    typedef enum logic [2:0] {
        ST_STOP = 3'h1,
        ST_WAIT = 3'h2,
        ST_RUN = 3'h4
    } octr_st_e;
endpackage : octr_pkg
`default_nettype wire

// ==== core/octr_top.sv ====
`default_nettype none
module octr_top #(
    parameter bit HAS_SPECIAL_PLL = 1'b0
) (
    input wire logic SYS_CLK,
    input wire logic RESET,
    input wire logic CLK_EN,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic SLEEP,
    input wire logic PRIMARY_CLK_IN,
    input wire logic CLKOUT_SEL,
    input wire logic GPIO_OUT,
    input wire logic GPIO_OE,
    output logic [5:0] RC_FREQ_TRIM,
    output logic REFCLK_OUT_PIN,
    output logic CRYSTAL_FEEDBACK_EN,
    output logic CRYSTAL_OUT_PIN_O,
    output logic CRYSTAL_OUT_PIN_OE,
    output logic PRIMARY_READY,
    output logic PRIMARY_ACTIVE,
    output logic [2:0] PLL_FACTOR
);
    ////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [1:0] pin_s1_reg, pin_s1_next;
    logic [1:0] pin_s2_reg, pin_s2_next;
    always_comb begin
        pin_s1_next = {SLEEP, PRIMARY_CLK_IN};
        pin_s2_next = pin_s1_reg;
    end
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            pin_s1_reg <= 2'h0;
            pin_s2_reg <= 2'h0;
        end else if (CLK_EN) begin
            pin_s1_reg <= pin_s1_next;
            pin_s2_reg <= pin_s2_next;
        end
    end
    logic sleep_s, pclk_s;
    assign sleep_s = pin_s2_reg[1];
    assign pclk_s = pin_s2_reg[0];

    ////////////////////////////////////////////////////////////////
    // apb register file
    logic [5:0] trim_reg, trim_next;
    logic ref_en_reg, ref_en_next;
    logic ref_slp_reg, ref_slp_next;
    logic ref_sel_reg, ref_sel_next;
    logic [3:0] ref_div_reg, ref_div_next;
    logic [1:0] sub_reg, sub_next;
    logic [2:0] isrc_reg, isrc_next;
    logic [31:0] prdata_reg, prdata_next;
    logic pready_reg, pready_next;
    logic pslverr_reg, pslverr_next;
    logic wr_acc, rd_acc;
    logic [2:0] cur_src;
    logic ost_done;

    function automatic logic addr_hit(input logic [7:0] a);
        addr_hit = (a == octr_pkg::TRIM_ADDR) || (a == octr_pkg::REFCTL_ADDR) ||
            (a == octr_pkg::OSCSTAT_ADDR) || (a == octr_pkg::OSCCFG_ADDR);
    endfunction : addr_hit

    // one wait state: answer in the second cycle after setup
    assign wr_acc = PSEL && PENABLE && !pready_reg && PWRITE && addr_hit(PADDR);
    assign rd_acc = PSEL && PENABLE && !pready_reg && !PWRITE;
    // pll only engaged for primary x4 selection
    assign cur_src = (isrc_reg == octr_pkg::SRC_PRIMARY_X4 && !(sub_reg == octr_pkg::SUB_HIGH &&
        !HAS_SPECIAL_PLL)) ? octr_pkg::SRC_PRIMARY_X4 :
        (isrc_reg == octr_pkg::SRC_PRIMARY_X4) ? octr_pkg::SRC_PRIMARY : isrc_reg;

    always_comb begin
        trim_next = trim_reg;
        ref_en_next = ref_en_reg;
        ref_slp_next = ref_slp_reg;
        ref_sel_next = ref_sel_reg;
        ref_div_next = ref_div_reg;
        sub_next = sub_reg;
        isrc_next = isrc_reg;
        prdata_next = prdata_reg;
        pready_next = PSEL && PENABLE && !pready_reg;
        pslverr_next = PSEL && PENABLE && !pready_reg && !addr_hit(PADDR);
        if (wr_acc) begin
            case (PADDR)
                octr_pkg::TRIM_ADDR: begin
                    trim_next = PWDATA[octr_pkg::TRIM_LSB +: octr_pkg::TRIM_W];
                end
                octr_pkg::REFCTL_ADDR: begin
                    ref_en_next = PWDATA[octr_pkg::REF_EN_BIT];
                    ref_slp_next = PWDATA[octr_pkg::REF_SLP_BIT];
                    ref_sel_next = PWDATA[octr_pkg::REF_SEL_BIT];
                    ref_div_next = PWDATA[octr_pkg::REF_DIV_LSB +: octr_pkg::REF_DIV_W];
                end
                octr_pkg::OSCCFG_ADDR: begin
                    sub_next = PWDATA[octr_pkg::SUBMODE_LSB +: 2];
                    isrc_next = PWDATA[octr_pkg::INITSRC_LSB +: 3];
                end
                default: begin
                end
            endcase
        end
        if (rd_acc) begin
            prdata_next = 32'h0000_0000;
            case (PADDR)
                octr_pkg::TRIM_ADDR: prdata_next[octr_pkg::TRIM_LSB +: octr_pkg::TRIM_W] = trim_reg;
                octr_pkg::REFCTL_ADDR: begin
                    prdata_next[octr_pkg::REF_EN_BIT] = ref_en_reg;
                    prdata_next[octr_pkg::REF_SLP_BIT] = ref_slp_reg;
                    prdata_next[octr_pkg::REF_SEL_BIT] = ref_sel_reg;
                    prdata_next[octr_pkg::REF_DIV_LSB +: octr_pkg::REF_DIV_W] = ref_div_reg;
                end
                octr_pkg::OSCSTAT_ADDR: begin
                    prdata_next[octr_pkg::CURSRC_LSB +: 3] = cur_src;
                    prdata_next[0] = ost_done;
                end
                octr_pkg::OSCCFG_ADDR: begin
                    prdata_next[octr_pkg::SUBMODE_LSB +: 2] = sub_reg;
                    prdata_next[octr_pkg::INITSRC_LSB +: 3] = isrc_reg;
                end
                default: prdata_next = 32'h0000_0000;
            endcase
        end
    end
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            trim_reg <= octr_pkg::TRIM_RST;
            ref_en_reg <= 1'b0;
            ref_slp_reg <= 1'b0;
            ref_sel_reg <= 1'b0;
            ref_div_reg <= 4'h0;
            sub_reg <= octr_pkg::CFG_RST_SUB;
            isrc_reg <= octr_pkg::CFG_RST_SRC;
            prdata_reg <= 32'h0000_0000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end else if (CLK_EN) begin
            trim_reg <= trim_next;
            ref_en_reg <= ref_en_next;
            ref_slp_reg <= ref_slp_next;
            ref_sel_reg <= ref_sel_next;
            ref_div_reg <= ref_div_next;
            sub_reg <= sub_next;
            isrc_reg <= isrc_next;
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
        end
    end

    ////////////////////////////////////////////////////////////////
    // primary mode decode and start-up timer
    logic prim_sel, is_crystal, is_ext;
    logic cfg_wr;
    // a new primary configuration restarts the oscillator
    assign cfg_wr = wr_acc && (PADDR == octr_pkg::OSCCFG_ADDR);
    assign prim_sel = (cur_src == octr_pkg::SRC_PRIMARY) || (cur_src == octr_pkg::SRC_PRIMARY_X4);
    assign is_ext = prim_sel && (sub_reg == octr_pkg::SUB_EXT);
    assign is_crystal = prim_sel && (sub_reg == octr_pkg::SUB_MED || sub_reg == octr_pkg::SUB_HIGH);

    octr_pkg::octr_st_e st_reg, st_next;
    logic [octr_pkg::STARTUP_W-1:0] ost_reg, ost_next;
    logic pclk_d_reg, pclk_d_next;
    logic rise;
    logic rdy_reg;
    assign rise = pclk_s && !pclk_d_reg;
    always_comb begin
        st_next = st_reg;
        ost_next = ost_reg;
        pclk_d_next = pclk_s;
        case (st_reg)
            octr_pkg::ST_STOP: begin
                ost_next = '0;
                if (is_ext) st_next = octr_pkg::ST_RUN;
                else if (is_crystal && !sleep_s) st_next = octr_pkg::ST_WAIT;
            end
            octr_pkg::ST_WAIT: begin
                if (!is_crystal || sleep_s || cfg_wr) st_next = octr_pkg::ST_STOP;
                else if (rise) begin
                    ost_next = ost_reg + 1'b1;
                    if (ost_reg == octr_pkg::STARTUP_W'(octr_pkg::STARTUP_CYCLES - 1))
                        st_next = octr_pkg::ST_RUN;
                end
            end
            octr_pkg::ST_RUN: begin
                if (!prim_sel || cfg_wr || (is_crystal && sleep_s)) st_next = octr_pkg::ST_STOP;
            end
            default: st_next = octr_pkg::ST_STOP;
        endcase
    end
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            st_reg <= octr_pkg::ST_STOP;
            ost_reg <= '0;
            pclk_d_reg <= 1'b0;
            rdy_reg <= 1'b0;
        end else if (CLK_EN) begin
            st_reg <= st_next;
            ost_reg <= ost_next;
            pclk_d_reg <= pclk_d_next;
            rdy_reg <= (st_next == octr_pkg::ST_RUN);
        end
    end
    assign ost_done = (st_reg == octr_pkg::ST_RUN);

    ////////////////////////////////////////////////////////////////
    // reference clock divider
    logic [15:0] rcnt_reg, rcnt_next;
    logic ref_out_reg, ref_out_next;
    logic [3:0] adiv_reg, adiv_next;
    logic asel_reg, asel_next;
    logic base_tick, ref_run, fin;
    // base is system clock edge, or a synced rising edge of the primary once it has reached run
    assign base_tick = asel_reg ? (rise && ost_done) : 1'b1;
    assign ref_run = ref_en_reg && (!sleep_s || ref_slp_reg);
    assign fin = (rcnt_reg == ((16'h0001 << adiv_reg) - 16'h0001));
    always_comb begin
        rcnt_next = rcnt_reg;
        ref_out_next = ref_out_reg;
        adiv_next = adiv_reg;
        asel_next = asel_reg;
        if (!ref_run) begin
            rcnt_next = 16'h0000;
            ref_out_next = 1'b0;
            adiv_next = ref_div_next;
            asel_next = ref_sel_next;
        end else if (adiv_reg == 4'h0) begin
            ref_out_next = asel_reg ? pclk_s : 1'b1;  // undivided: follow primary, held high on system base
            if (ref_div_reg != adiv_reg || ref_sel_reg != asel_reg) begin
                adiv_next = ref_div_reg;
                asel_next = ref_sel_reg;
            end
        end else if (base_tick) begin
            // full period of 2^div counts base edges; full cycle ends low
            if (fin) begin
                rcnt_next = 16'h0000;
                ref_out_next = 1'b0;
                adiv_next = ref_div_reg;
                asel_next = ref_sel_reg;
            end else begin
                rcnt_next = rcnt_reg + 16'h0001;
                if (rcnt_reg == ((16'h0001 << adiv_reg) >> 1) - 16'h0001) ref_out_next = 1'b1;
            end
        end
    end
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            rcnt_reg <= 16'h0000;
            ref_out_reg <= 1'b0;
            adiv_reg <= 4'h0;
            asel_reg <= 1'b0;
        end else if (CLK_EN) begin
            rcnt_reg <= rcnt_next;
            ref_out_reg <= ref_out_next;
            adiv_reg <= adiv_next;
            asel_reg <= asel_next;
        end
    end

    ////////////////////////////////////////////////////////////////
    // pin control
    logic fb_reg, o_reg, oe_reg, half_reg, act_reg;
    logic [2:0] pll_reg;
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            fb_reg <= 1'b0;
            o_reg <= 1'b0;
            oe_reg <= 1'b0;
            half_reg <= 1'b0;
            pll_reg <= 3'h1;
            act_reg <= 1'b0;
        end else if (CLK_EN) begin
            fb_reg <= is_crystal;
            half_reg <= (is_ext && rise) ? !half_reg : half_reg;
            o_reg <= is_ext ? (CLKOUT_SEL ? half_reg : GPIO_OUT) : 1'b0;
            oe_reg <= is_ext ? (CLKOUT_SEL || GPIO_OE) : 1'b0;
            pll_reg <= (cur_src == octr_pkg::SRC_PRIMARY_X4) ? 3'(octr_pkg::PLL_MULT) : 3'h1;
            act_reg <= fb_reg || oe_reg || ost_done;
        end
    end

    assign PRDATA = prdata_reg;
    assign PREADY = pready_reg;
    assign PSLVERR = pslverr_reg;
    assign RC_FREQ_TRIM = trim_reg;
    assign REFCLK_OUT_PIN = ref_out_reg;
    assign CRYSTAL_FEEDBACK_EN = fb_reg;
    assign CRYSTAL_OUT_PIN_O = o_reg;
    assign CRYSTAL_OUT_PIN_OE = oe_reg;
    assign PRIMARY_READY = rdy_reg;
    assign PRIMARY_ACTIVE = act_reg;
    assign PLL_FACTOR = pll_reg;

    ////////////////////////////////////////////////////////////////
    // assertions
    property p_trim_clear;
        @(posedge SYS_CLK) $fell(RESET) |-> RC_FREQ_TRIM == 6'h00;
    endproperty
    a_trim_clear: assert property (p_trim_clear) else $error("trim not cleared");
    property p_trim_rd;
        @(posedge SYS_CLK) disable iff (RESET)
        CLK_EN && rd_acc && PADDR == octr_pkg::TRIM_ADDR |=> PRDATA[31:6] == 26'h0;
    endproperty
    a_trim_rd: assert property (p_trim_rd) else $error("trim upper bits nonzero");
    property p_ref_rd;
        @(posedge SYS_CLK) disable iff (RESET)
        CLK_EN && rd_acc && PADDR == octr_pkg::REFCTL_ADDR |=> PRDATA[14] == 1'b0 && PRDATA[7:0] == 8'h00;
    endproperty
    a_ref_rd: assert property (p_ref_rd) else $error("ref reserved bits nonzero");
    property p_ref_off;
        @(posedge SYS_CLK) disable iff (RESET) CLK_EN && !ref_run |=> !REFCLK_OUT_PIN && rcnt_reg == 16'h0;
    endproperty
    a_ref_off: assert property (p_ref_off) else $error("ref out not held low");
    property p_trim_wr;
        @(posedge SYS_CLK) disable iff (RESET)
        CLK_EN && wr_acc && PADDR == octr_pkg::TRIM_ADDR |=> RC_FREQ_TRIM == $past(PWDATA[5:0]);
    endproperty
    a_trim_wr: assert property (p_trim_wr) else $error("trim write lost");
    property p_fb;
        @(posedge SYS_CLK) disable iff (RESET) CLK_EN && is_ext |=> !CRYSTAL_FEEDBACK_EN;
    endproperty
    a_fb: assert property (p_fb) else $error("feedback on in external mode");
    property p_xtal_pin;
        @(posedge SYS_CLK) disable iff (RESET) CLK_EN && is_crystal |=> !CRYSTAL_OUT_PIN_OE;
    endproperty
    a_xtal_pin: assert property (p_xtal_pin) else $error("output pin driven in crystal mode");
    property p_ost;
        @(posedge SYS_CLK) disable iff (RESET)
        $rose(ost_done) && is_crystal |-> $past(ost_reg) == 10'h3FF;
    endproperty
    a_ost: assert property (p_ost) else $error("start-up released early");
    property p_pll;
        @(posedge SYS_CLK) disable iff (RESET)
        CLK_EN && cur_src == octr_pkg::SRC_PRIMARY_X4 |=> PLL_FACTOR == 3'h4;
    endproperty
    a_pll: assert property (p_pll) else $error("pll factor wrong");
    property p_ref_flat;
        @(posedge SYS_CLK) disable iff (RESET)
        CLK_EN && ref_run && adiv_reg == 4'h0 && !asel_reg |=> REFCLK_OUT_PIN;
    endproperty
    a_ref_flat: assert property (p_ref_flat) else $error("undivided system reference not high");
    property p_clkout;
        @(posedge SYS_CLK) disable iff (RESET)
        CLK_EN && is_ext && CLKOUT_SEL |=> CRYSTAL_OUT_PIN_OE;
    endproperty
    a_clkout: assert property (p_clkout) else $error("clock out pin not driven");
endmodule : octr_top
`default_nettype wire

// ==== verification/octr_osc_model.sv ====
`default_nettype none
module octr_osc_model #(
    parameter int HALF_NS = 40
) (
    input wire logic enable,
    output logic clk_out
);
    timeunit 1ns;
    timeprecision 1ns;
    initial clk_out = 1'b0;
    // cmos driver on the input pin, parked low when unpowered
    always begin
        #(HALF_NS);
        clk_out = enable ? ~clk_out : 1'b0;
    end
endmodule : octr_osc_model
`default_nettype wire

// ==== verification/octr_top_tb_top.sv ====
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin miscompares++; \
    $display("[ERR] t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module octr_top_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic sleep = 1'b0;
    logic clkout_sel = 1'b0;
    logic gpio_out = 1'b0;
    logic gpio_oe = 1'b0;
    logic clk_en = 1'b1;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic ref_pin;
    logic fb_en;
    logic c2_o;
    logic c2_oe;
    logic p_ready;
    logic p_active;
    logic osc_clk;
    logic [5:0] trim_pin;
    logic [2:0] pll;
    int miscompares = 0;
    int comparisons = 0;
    int cycles = 0;
    int seed = 52262;
    int model_regs[4] = '{default: 0};

    always #10 clk = ~clk;

    octr_osc_model i_octr_osc_model (.enable(1'b1), .clk_out(osc_clk));

    octr_top #(.HAS_SPECIAL_PLL(1'b0)) i_octr_top (
        .SYS_CLK(clk), .RESET(rst), .CLK_EN(clk_en), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .SLEEP(sleep), .PRIMARY_CLK_IN(osc_clk), .CLKOUT_SEL(clkout_sel),
        .GPIO_OUT(gpio_out), .GPIO_OE(gpio_oe), .RC_FREQ_TRIM(trim_pin), .REFCLK_OUT_PIN(ref_pin),
        .CRYSTAL_FEEDBACK_EN(fb_en), .CRYSTAL_OUT_PIN_O(c2_o), .CRYSTAL_OUT_PIN_OE(c2_oe),
        .PRIMARY_READY(p_ready), .PRIMARY_ACTIVE(p_active), .PLL_FACTOR(pll)
    );

    task automatic complete_run();
        $display("counts: comparisons=%0d miscompares=%0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : complete_run

    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            miscompares++;
            complete_run();
        end
    end

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input int d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
        // register model: only implemented bits hold a value
        if (a == octr_pkg::TRIM_ADDR) model_regs[0] = d & 32'h3F;
        else if (a == octr_pkg::REFCTL_ADDR) model_regs[1] = d & 32'hBF00;
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input int exp, input logic exp_err);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        `CHK(r, exp)
        `CHK(e, exp_err)
    endtask : rd_chk

    task automatic count_edges(input int n, output int c);
        logic prev;
        c = 0;
        prev = ref_pin;
        repeat (n) begin
            @(posedge clk);
            if (ref_pin === 1'b1 && prev === 1'b0) c++;
            prev = ref_pin;
        end
    endtask : count_edges

    int m;
    int c;
    int src;
    int sub;
    int bnd[5] = '{32'h1F, 32'h00, 32'h20, 32'h3F, 32'hFFFF_FFC0};
    int sub_t[6] = '{0, 0, 2, 2, 1, 1};
    int x4_t[6] = '{0, 1, 0, 1, 0, 1};

    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rd_chk(octr_pkg::TRIM_ADDR, 0, 1'b0);
        rd_chk(octr_pkg::REFCTL_ADDR, 0, 1'b0);
        $display("test reset_values done");
        for (int i = 0; i < 9; i++) begin
            m = (i < 5) ? bnd[i] : $random(seed);
            wr(octr_pkg::TRIM_ADDR, m);
            m = m & 32'h3F;
            rd_chk(octr_pkg::TRIM_ADDR, model_regs[0], 1'b0);
            `CHK(trim_pin, m[5:0])
        end
        wr(8'h10, 32'hFFFF_FFFF);
        rd_chk(8'h10, 0, 1'b1);
        rd_chk(octr_pkg::TRIM_ADDR, model_regs[0], 1'b0);
        wr(octr_pkg::REFCTL_ADDR, 32'hFFFF_FFFF);
        rd_chk(octr_pkg::REFCTL_ADDR, model_regs[1], 1'b0);
        $display("test registers done");
        // stalled primary base: disable so the next divisor loads at once
        wr(octr_pkg::REFCTL_ADDR, 32'h0000);
        for (int d = 1; d < 6; d++) begin
            wr(octr_pkg::REFCTL_ADDR, 32'h8000 | (d << 8));
            repeat (1 << (d + 2)) @(posedge clk);
            count_edges(256, c);
            `CHK((c >= (256 >> d) - 1 && c <= (256 >> d) + 1), 1'b1)
        end
        wr(octr_pkg::REFCTL_ADDR, 32'h8000);
        repeat (40) @(posedge clk);
        count_edges(64, c);
        `CHK(c, 0)
        `CHK(ref_pin, 1'b1)
        wr(octr_pkg::REFCTL_ADDR, 32'h0F00);
        repeat (8) @(posedge clk);
        count_edges(64, c);
        `CHK(c, 0)
        `CHK(ref_pin, 1'b0)
        $display("test divider done");
        for (int k = 0; k < 6; k++) begin
            sub = sub_t[k];
            src = x4_t[k] ? 3 : 2;
            wr(octr_pkg::OSCCFG_ADDR, (src << 8) | sub);
            repeat (3900) @(posedge clk);
            if (sub != 0) `CHK(p_ready, 1'b0)
            repeat (600) @(posedge clk);
            `CHK(p_ready, 1'b1)
            `CHK(p_active, 1'b1)
            m = (x4_t[k] && sub != 2) ? 3 : 2;
            rd_chk(octr_pkg::OSCSTAT_ADDR, (m << 12) | 1, 1'b0);
            `CHK(pll, (m == 3) ? 3'h4 : 3'h1)
            `CHK(fb_en, (sub != 0))
            if (sub == 0) begin
                clkout_sel <= 1'b1;
                repeat (4) @(posedge clk);
                `CHK(c2_oe, 1'b1)
                // primary period is four system cycles: a toggle every four
                c = 0;
                m = c2_o;
                repeat (64) begin
                    @(posedge clk);
                    if (c2_o !== m[0]) c++;
                    m = c2_o;
                end
                `CHK((c >= 15 && c <= 17), 1'b1)
                clkout_sel <= 1'b0;
                gpio_oe <= 1'($random(seed));
                gpio_out <= 1'($random(seed));
                repeat (4) @(posedge clk);
                `CHK(c2_oe, gpio_oe)
                `CHK(c2_o, gpio_out)
            end
        end
        $display("test primary_modes done");
        wr(octr_pkg::REFCTL_ADDR, 32'h9100);
        repeat (16) @(posedge clk);
        count_edges(200, c);
        `CHK((c >= 23 && c <= 27), 1'b1)
        sleep <= 1'b1;
        wr(octr_pkg::REFCTL_ADDR, 32'h8100);
        repeat (8) @(posedge clk);
        count_edges(128, c);
        `CHK(c, 0)
        wr(octr_pkg::REFCTL_ADDR, 32'hA100);
        repeat (8) @(posedge clk);
        count_edges(128, c);
        `CHK((c >= 63 && c <= 65), 1'b1)
        clk_en <= 1'b0;
        @(posedge clk);
        m = ref_pin;
        repeat (10) @(posedge clk);
        `CHK(ref_pin, m[0])
        clk_en <= 1'b1;
        sleep <= 1'b0;
        $display("test source_sleep done");
        wr(octr_pkg::TRIM_ADDR, 32'h15);
        `CHK(trim_pin, 6'h15)
        rst <= 1'b1;
        model_regs = '{default: 0};
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        `CHK(trim_pin, 6'h00)
        rd_chk(octr_pkg::TRIM_ADDR, model_regs[0], 1'b0);
        rd_chk(octr_pkg::REFCTL_ADDR, model_regs[1], 1'b0);
        $display("test second_reset done");
        complete_run();
    end
endmodule : octr_top_tb_top
`default_nettype wire
